// *** srlcs_pkg.sv ***
// constants, register map and carrier types of the receive lane crossbar and status block
// assumes one parallel lane clock for registers, lanes and error inputs
//
// Overview of operation
// - each logical lane has 3-bit source select, odd lanes upper field, even lower
// - after reset logical lanes 0 and 1 take physical lanes 0 and 1
// - after reset logical lanes 2 and 3 take physical lanes 2 and 3
// - after reset logical lanes 4 and 5 take physical lanes 4 and 5
// - after reset logical lanes 6 and 7 take physical lanes 6 and 7
// - read-only 8-bit vector shows which logical lane buffers are full
// - read-only 8-bit vector shows which logical lane buffers are empty
// - sync error raised at multiframe end after any decode error within it
// - 2-bit field sets how long both sync outputs stay low for an error
// - 8-bit enable vector turns on the bit error test per lane, resets zero

package srlcs_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NLANE = 8;
  localparam int LANE_W = 32;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NPAIR = 4;
  localparam int NSYNC = 2;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ROUTE_0 = 10'h308;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_1 = 10'h309;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_2 = 10'h30A;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_3 = 10'h30B;
  localparam logic [ADDR_W-1:0] OFS_FULL = 10'h30C;
  localparam logic [ADDR_W-1:0] OFS_EMPTY = 10'h30D;
  localparam logic [ADDR_W-1:0] OFS_SYNC_CFG = 10'h312;
  localparam logic [ADDR_W-1:0] OFS_PHY_SETUP = 10'h314;
  localparam logic [ADDR_W-1:0] OFS_BERT_EN = 10'h315;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 10'h3F0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 10'h3F1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 10'h3F2;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int SYNC_DUR_LSB = 4;
  localparam int SYNC_DUR_W = 2;
  localparam logic [DATA_W-1:0] ROUTE_WR_MASK = 8'h3F;
  localparam logic [SEL_W-1:0] SRC_RST_0 = 3'h0;
  localparam logic [SEL_W-1:0] SRC_RST_1 = 3'h1;
  localparam logic [SEL_W-1:0] SRC_RST_2 = 3'h2;
  localparam logic [SEL_W-1:0] SRC_RST_3 = 3'h3;
  localparam logic [SEL_W-1:0] SRC_RST_4 = 3'h4;
  localparam logic [SEL_W-1:0] SRC_RST_5 = 3'h5;
  localparam logic [SEL_W-1:0] SRC_RST_6 = 3'h6;
  localparam logic [SEL_W-1:0] SRC_RST_7 = 3'h7;
  localparam logic [DATA_W-1:0] SYNC_CFG_RST = 8'h10;
  localparam logic [DATA_W-1:0] PHY_SETUP_RST = 8'h00;
  localparam logic [DATA_W-1:0] BERT_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // ---------------------------------------------------------------
  // sync error pulse length
  // ---------------------------------------------------------------
  localparam logic [SYNC_DUR_W-1:0] DUR_HALF = 2'h0;
  localparam logic [SYNC_DUR_W-1:0] DUR_ONE = 2'h1;
  localparam logic [SYNC_DUR_W-1:0] DUR_TWO = 2'h2;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;

  // ---------------------------------------------------------------
  // interrupt bits
  // ---------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_FULL = 1;
  localparam int IRQ_EMPTY = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsvd;
    logic [SEL_W-1:0] odd_src;
    logic [SEL_W-1:0] even_src;
  } srlcs_route_t;

  typedef struct packed {
    logic [NLANE-1:0] disparity;
    logic [NLANE-1:0] not_in_table;
    logic [NLANE-1:0] unexpected_ctrl;
  } srlcs_dec_err_t;

  typedef logic [NLANE-1:0][LANE_W-1:0] srlcs_lane_bus_t;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_HOLD = 2'b10
  } srlcs_sync_state_t;

endpackage : srlcs_pkg

// *** srlcs_lane_mux.sv ***
// one logical lane of the crossbar: picks a physical lane, registered
// assumes select and lanes are on the lane clock
`timescale 1ns/100ps
`default_nettype none

module srlcs_lane_mux (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire srlcs_pkg::srlcs_lane_bus_t phys_data_i,
  input wire logic [srlcs_pkg::NLANE-1:0] phys_valid_i,
  input wire logic [srlcs_pkg::SEL_W-1:0] sel_i,
  output logic [srlcs_pkg::LANE_W-1:0] data_o,
  output logic valid_o
);
  import srlcs_pkg::*;

  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  wire logic [LANE_W-1:0] data_next;
  wire logic valid_next;
  assign data_next = phys_data_i[sel_i];
  assign valid_next = phys_valid_i[sel_i];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_o <= '0;
      valid_o <= 1'b0;
    end else begin
      data_o <= data_next;
      valid_o <= valid_next;
    end
  end

endmodule : srlcs_lane_mux

`default_nettype wire

// *** srlcs_top.sv ***
// receive lane crossbar, lane buffer status, sync error pulse and bit error test enables
// assumes lanes, buffer flags, decode errors and multiframe end arrive on clk_i
`timescale 1ns/100ps
`default_nettype none

module srlcs_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [srlcs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [srlcs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [srlcs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire srlcs_pkg::srlcs_lane_bus_t physical_input_lane_i,
  input wire logic [srlcs_pkg::NLANE-1:0] physical_input_valid_i,
  output srlcs_pkg::srlcs_lane_bus_t logical_lane_data_o,
  output logic [srlcs_pkg::NLANE-1:0] logical_lane_valid_o,
  input wire logic [srlcs_pkg::NLANE-1:0] lane_fifo_full_i,
  input wire logic [srlcs_pkg::NLANE-1:0] lane_fifo_empty_i,
  input wire srlcs_pkg::srlcs_dec_err_t dec_err_i,
  input wire logic mf_end_i,
  output logic [srlcs_pkg::NSYNC-1:0] sync_request_output_n_o,
  output logic [srlcs_pkg::NLANE-1:0] bit_error_test_enable_o,
  output logic [srlcs_pkg::DATA_W-1:0] lane_phy_setup_value_o,
  output logic irq_o
);
  import srlcs_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  srlcs_route_t route_reg [NPAIR];
  logic [DATA_W-1:0] sync_cfg_reg;
  logic [DATA_W-1:0] phy_setup_reg;
  logic [NLANE-1:0] bert_en_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic irq_reg;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic [NPAIR-1:0] route_wr;
  wire logic sync_cfg_wr;
  wire logic phy_setup_wr;
  wire logic bert_en_wr;
  wire logic irq_clr_wr;
  wire logic irq_en_wr;
  assign route_wr[0] = reg_wr_i && (reg_addr_i == OFS_ROUTE_0);
  assign route_wr[1] = reg_wr_i && (reg_addr_i == OFS_ROUTE_1);
  assign route_wr[2] = reg_wr_i && (reg_addr_i == OFS_ROUTE_2);
  assign route_wr[3] = reg_wr_i && (reg_addr_i == OFS_ROUTE_3);
  assign sync_cfg_wr = reg_wr_i && (reg_addr_i == OFS_SYNC_CFG);
  assign phy_setup_wr = reg_wr_i && (reg_addr_i == OFS_PHY_SETUP);
  assign bert_en_wr = reg_wr_i && (reg_addr_i == OFS_BERT_EN);
  assign irq_clr_wr = reg_wr_i && (reg_addr_i == OFS_IRQ_CLR);
  assign irq_en_wr = reg_wr_i && (reg_addr_i == OFS_IRQ_EN);

  // ---------------------------------------------------------------
  // crossbar select registers
  // ---------------------------------------------------------------
  wire srlcs_route_t route_wdata;
  assign route_wdata = srlcs_route_t'(reg_wdata_i & ROUTE_WR_MASK);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      route_reg[0] <= '{rsvd: 2'h0, odd_src: SRC_RST_1, even_src: SRC_RST_0};
      route_reg[1] <= '{rsvd: 2'h0, odd_src: SRC_RST_3, even_src: SRC_RST_2};
      route_reg[2] <= '{rsvd: 2'h0, odd_src: SRC_RST_5, even_src: SRC_RST_4};
      route_reg[3] <= '{rsvd: 2'h0, odd_src: SRC_RST_7, even_src: SRC_RST_6};
    end else begin
      for (int p = 0; p < NPAIR; p++) begin
        if (route_wr[p]) begin
          route_reg[p] <= route_wdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // logical lane sources
  // ---------------------------------------------------------------
  wire logic [SEL_W-1:0] logical_lane_zero_source;
  wire logic [SEL_W-1:0] logical_lane_one_source;
  wire logic [SEL_W-1:0] logical_lane_two_source;
  wire logic [SEL_W-1:0] logical_lane_three_source;
  wire logic [SEL_W-1:0] logical_lane_four_source;
  wire logic [SEL_W-1:0] logical_lane_five_source;
  wire logic [SEL_W-1:0] logical_lane_six_source;
  wire logic [SEL_W-1:0] logical_lane_seven_source;
  wire logic [NLANE-1:0][SEL_W-1:0] lane_sel;
  assign logical_lane_zero_source = route_reg[0].even_src;
  assign logical_lane_one_source = route_reg[0].odd_src;
  assign logical_lane_two_source = route_reg[1].even_src;
  assign logical_lane_three_source = route_reg[1].odd_src;
  assign logical_lane_four_source = route_reg[2].even_src;
  assign logical_lane_five_source = route_reg[2].odd_src;
  assign logical_lane_six_source = route_reg[3].even_src;
  assign logical_lane_seven_source = route_reg[3].odd_src;
  assign lane_sel = {logical_lane_seven_source, logical_lane_six_source,
                     logical_lane_five_source, logical_lane_four_source,
                     logical_lane_three_source, logical_lane_two_source,
                     logical_lane_one_source, logical_lane_zero_source};

  // ---------------------------------------------------------------
  // crossbar
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NLANE; g++) begin : g_lane
      srlcs_lane_mux u_mux (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .phys_data_i(physical_input_lane_i),
        .phys_valid_i(physical_input_valid_i),
        .sel_i(lane_sel[g]),
        .data_o(logical_lane_data_o[g]),
        .valid_o(logical_lane_valid_o[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // config and test enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_cfg_reg <= SYNC_CFG_RST;
      phy_setup_reg <= PHY_SETUP_RST;
      bert_en_reg <= BERT_EN_RST;
    end else begin
      if (sync_cfg_wr) begin
        sync_cfg_reg <= reg_wdata_i;
      end
      if (phy_setup_wr) begin
        phy_setup_reg <= reg_wdata_i;
      end
      if (bert_en_wr) begin
        bert_en_reg <= reg_wdata_i;
      end
    end
  end

  assign bit_error_test_enable_o = bert_en_reg;
  assign lane_phy_setup_value_o = phy_setup_reg;

  // ---------------------------------------------------------------
  // decode error collection over a multiframe
  // ---------------------------------------------------------------
  logic err_seen_reg;
  wire logic err_now;
  wire logic sync_fire;
  assign err_now = |dec_err_i.disparity || |dec_err_i.not_in_table || |dec_err_i.unexpected_ctrl;
  assign sync_fire = mf_end_i && (err_seen_reg || err_now);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      err_seen_reg <= 1'b0;
    end else if (mf_end_i) begin
      err_seen_reg <= 1'b0;
    end else if (err_now) begin
      err_seen_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sync error pulse
  // ---------------------------------------------------------------
  srlcs_sync_state_t sync_state_reg;
  srlcs_sync_state_t sync_state_next;
  logic [1:0] sync_cnt_reg;
  logic [1:0] sync_cnt_next;
  logic [NSYNC-1:0] sync_n_reg;
  logic [NSYNC-1:0] sync_n_next;
  wire logic [SYNC_DUR_W-1:0] sync_dur;
  wire logic [1:0] sync_len;
  assign sync_dur = sync_cfg_reg[SYNC_DUR_LSB +: SYNC_DUR_W];
  // half cycle rounds up to one whole cycle on a single edge
  assign sync_len = (sync_dur == DUR_TWO) ? LEN_TWO :
                    (sync_dur == DUR_ONE) ? LEN_ONE :
                    (sync_dur == DUR_HALF) ? LEN_ONE : LEN_TWO;

  always_comb begin
    sync_state_next = sync_state_reg;
    sync_cnt_next = sync_cnt_reg;
    sync_n_next = {NSYNC{1'b1}};
    case (sync_state_reg)
      SYNC_IDLE: begin
        if (sync_fire) begin
          sync_state_next = SYNC_HOLD;
          sync_cnt_next = sync_len - CNT_STEP;
          sync_n_next = {NSYNC{1'b0}};
        end
      end
      SYNC_HOLD: begin
        if (sync_cnt_reg != CNT_ZERO) begin
          sync_cnt_next = sync_cnt_reg - CNT_STEP;
          sync_n_next = {NSYNC{1'b0}};
        end else if (sync_fire) begin
          sync_cnt_next = sync_len - CNT_STEP;
          sync_n_next = {NSYNC{1'b0}};
        end else begin
          sync_state_next = SYNC_IDLE;
        end
      end
      default: begin
        sync_state_next = SYNC_IDLE;
        sync_cnt_next = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_state_reg <= SYNC_IDLE;
      sync_cnt_reg <= CNT_ZERO;
      sync_n_reg <= {NSYNC{1'b1}};
    end else begin
      sync_state_reg <= sync_state_next;
      sync_cnt_reg <= sync_cnt_next;
      sync_n_reg <= sync_n_next;
    end
  end

  assign sync_request_output_n_o = sync_n_reg;

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic full_any_reg;
  logic empty_any_reg;
  wire logic full_any;
  wire logic empty_any;
  wire logic [IRQ_W-1:0] irq_event;
  wire logic [IRQ_W-1:0] irq_clr;
  assign full_any = |lane_fifo_full_i;
  assign empty_any = |lane_fifo_empty_i;
  assign irq_event[IRQ_SYNC] = sync_fire;
  assign irq_event[IRQ_FULL] = full_any && !full_any_reg;
  assign irq_event[IRQ_EMPTY] = empty_any && !empty_any_reg;
  assign irq_clr = irq_clr_wr ? reg_wdata_i[IRQ_W-1:0] : IRQ_RST;

  // set wins over a clear in the same cycle
  always_comb begin
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_event;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      full_any_reg <= 1'b0;
      empty_any_reg <= 1'b0;
      irq_stat_reg <= IRQ_RST;
      irq_en_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      full_any_reg <= full_any;
      empty_any_reg <= empty_any;
      irq_stat_reg <= irq_stat_next;
      if (irq_en_wr) begin
        irq_en_reg <= reg_wdata_i[IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_next & (irq_en_wr ? reg_wdata_i[IRQ_W-1:0] : irq_en_reg));
    end
  end

  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = RD_IDLE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_ROUTE_0: rdata_next = route_reg[0];
        OFS_ROUTE_1: rdata_next = route_reg[1];
        OFS_ROUTE_2: rdata_next = route_reg[2];
        OFS_ROUTE_3: rdata_next = route_reg[3];
        OFS_FULL: rdata_next = lane_fifo_full_i;
        OFS_EMPTY: rdata_next = lane_fifo_empty_i;
        OFS_SYNC_CFG: rdata_next = sync_cfg_reg;
        OFS_PHY_SETUP: rdata_next = phy_setup_reg;
        OFS_BERT_EN: rdata_next = bert_en_reg;
        OFS_IRQ_STAT: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
        OFS_IRQ_EN: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_en_reg};
        default: rdata_next = RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= RD_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule : srlcs_top

`default_nettype wire

// *** srlcs_asserts.sv ***
// checker for the receive lane crossbar, flag reads, sync pulse and setup outputs
// assumes binding to srlcs_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none

module srlcs_asserts (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [srlcs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [srlcs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [srlcs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire srlcs_pkg::srlcs_lane_bus_t physical_input_lane_i,
  input wire srlcs_pkg::srlcs_lane_bus_t logical_lane_data_o,
  input wire logic [srlcs_pkg::NLANE-1:0] lane_fifo_full_i,
  input wire logic [srlcs_pkg::NLANE-1:0] lane_fifo_empty_i,
  input wire srlcs_pkg::srlcs_dec_err_t dec_err_i,
  input wire logic mf_end_i,
  input wire logic [srlcs_pkg::NSYNC-1:0] sync_request_output_n_o,
  input wire logic [srlcs_pkg::NLANE-1:0] bit_error_test_enable_o,
  input wire logic [srlcs_pkg::DATA_W-1:0] lane_phy_setup_value_o
);
  import srlcs_pkg::*;
  logic [DATA_W-1:0] route_reg [NPAIR];
  logic [SYNC_DUR_W-1:0] dur_reg;
  logic [LANE_W-1:0] pick_w [NLANE];
  wire [1:0] so_w = sync_request_output_n_o;
  wire wr_route_w = reg_wr_i && reg_addr_i[9:2] == OFS_ROUTE_0[9:2];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // shadow of route selects and pulse length
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      route_reg <= '{8'h08, 8'h1A, 8'h2C, 8'h3E};
      dur_reg <= 2'h1;
    end else begin
      if (wr_route_w) route_reg[reg_addr_i[1:0]] <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == OFS_SYNC_CFG) dur_reg <= reg_wdata_i[5:4];
    end
  end

  for (genvar l = 0; l < NLANE; l++) begin : g_lane
    assign pick_w[l] = physical_input_lane_i[(l % 2) ? route_reg[l / 2][5:3] : route_reg[l / 2][2:0]];
    AST_XBAR_ROUTE: assert property (
      $past(rstn_i) |-> logical_lane_data_o[l] == $past(pick_w[l])
    ) else $error("logical lane not from selected source");
  end

  AST_FULL_READ: assert property (
    reg_rd_i && reg_addr_i == OFS_FULL |=> reg_rdata_o == $past(lane_fifo_full_i)
  ) else $error("full flags read wrong");
  AST_EMPTY_READ: assert property (
    reg_rd_i && reg_addr_i == OFS_EMPTY |=> reg_rdata_o == $past(lane_fifo_empty_i)
  ) else $error("empty flags read wrong");
  AST_SYNC_FIRE: assert property (
    mf_end_i && (|dec_err_i) |=> so_w == 2'b00
  ) else $error("no sync error after faulty multiframe");
  AST_SYNC_CAUSE: assert property (
    $fell(so_w[0]) |-> $past(mf_end_i)
  ) else $error("sync error away from multiframe end");
  AST_SYNC_SAME: assert property (
    so_w[0] == so_w[1]
  ) else $error("sync outputs differ");
  AST_SYNC_SHORT: assert property (
    $fell(so_w[0]) && !dur_reg[1] && !mf_end_i |=> so_w == 2'b11
  ) else $error("one cycle sync pulse wrong length");
  AST_SYNC_LONG: assert property (
    $fell(so_w[0]) && dur_reg[1] && !mf_end_i ##1 !mf_end_i |-> so_w == 2'b00 ##1 so_w == 2'b11
  ) else $error("two cycle sync pulse wrong length");
  AST_PHY_SETUP: assert property (
    reg_wr_i && reg_addr_i == OFS_PHY_SETUP |=> lane_phy_setup_value_o == $past(reg_wdata_i)
  ) else $error("phy setup output not written");
  AST_BERT_EN: assert property (
    reg_wr_i && reg_addr_i == OFS_BERT_EN |=> bit_error_test_enable_o == $past(reg_wdata_i)
  ) else $error("test enables not written");
endmodule : srlcs_asserts

bind srlcs_top srlcs_asserts i_srlcs_asserts (
  .clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .physical_input_lane_i, .logical_lane_data_o, .lane_fifo_full_i, .lane_fifo_empty_i,
  .dec_err_i, .mf_end_i, .sync_request_output_n_o, .bit_error_test_enable_o, .lane_phy_setup_value_o
);
`default_nettype wire

// *** srlcs_far_end.sv ***
// far-end transmitter model: lane stream, multiframe ends, decode error pulses
// assumes error requests come from the bench on the lane clock
`timescale 1ns/100ps
`default_nettype none

module srlcs_far_end (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic err_i,
  input wire logic [1:0] err_kind_i,
  output var srlcs_pkg::srlcs_lane_bus_t lane_o,
  output logic [srlcs_pkg::NLANE-1:0] valid_o,
  output var srlcs_pkg::srlcs_dec_err_t dec_err_o,
  output logic mf_end_o
);
  import srlcs_pkg::*;
  logic [15:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // lane id on top, running count below, so route and latency both show
  for (genvar l = 0; l < NLANE; l++) begin : g_lane
    assign lane_o[l] = {8'(l), 8'h5A ^ 8'(l), cnt_reg};
  end
  assign valid_o = cnt_reg[7:0] ^ 8'h3C;
  // multiframe of 16 lane clocks
  assign mf_end_o = (cnt_reg[3:0] == 4'hF);

  // one error kind per request, on differing lanes
  always_comb begin
    dec_err_o = '0;
    case (err_kind_i)
      2'h0: dec_err_o.disparity[0] = err_i;
      2'h1: dec_err_o.not_in_table[3] = err_i;
      default: dec_err_o.unexpected_ctrl[6] = err_i;
    endcase
  end
endmodule : srlcs_far_end
`default_nettype wire

// *** srlcs_bench.sv ***
// self-checking bench for the receive lane crossbar and status block
// assumes srlcs_top, the checker bind and the far-end model are compiled first
`timescale 1ns/100ps
`default_nettype none

module srlcs_bench;
  import srlcs_pkg::*;
  logic clk_i, rstn_i, wr, rd, err, mf_end, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, phy_w, bert_w;
  logic [1:0] err_kind, sync_n;
  logic [NLANE-1:0] full, empty, pvalid, lvalid;
  logic [31:0] exp;
  srlcs_lane_bus_t plane, llane;
  srlcs_dec_err_t dec_err;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int lows;

  srlcs_top i_srlcs_top (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .physical_input_lane_i(plane), .physical_input_valid_i(pvalid),
    .logical_lane_data_o(llane), .logical_lane_valid_o(lvalid), .lane_fifo_full_i(full),
    .lane_fifo_empty_i(empty), .dec_err_i(dec_err), .mf_end_i(mf_end), .sync_request_output_n_o(sync_n),
    .bit_error_test_enable_o(bert_w), .lane_phy_setup_value_o(phy_w), .irq_o(irq)
  );
  srlcs_far_end i_srlcs_far_end (
    .clk_i(clk_i), .rstn_i(rstn_i), .err_i(err), .err_kind_i(err_kind), .lane_o(plane),
    .valid_o(pvalid), .dec_err_o(dec_err), .mf_end_o(mf_end)
  );

  always #5 clk_i = ~clk_i;

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask : check

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    check(rdata, e);
  endtask : rd_check

  // counts low sync cycles over forty clocks after an optional error
  task automatic sync_run(input logic [1:0] dur, input logic with_err, output int n);
    reg_write(OFS_SYNC_CFG, {2'h0, dur, 4'h0});
    @(posedge clk_i);
    err <= with_err;
    err_kind <= dur;
    @(posedge clk_i);
    err <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (sync_n === 2'b00) n++;
    end
  endtask : sync_run

  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    addr = '0;
    wdata = '0;
    {wr, rd, err, err_kind, full, empty} = '0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_check(OFS_ROUTE_0, 8'h08);
    rd_check(OFS_ROUTE_1, 8'h1A);
    rd_check(OFS_ROUTE_2, 8'h2C);
    rd_check(OFS_ROUTE_3, 8'h3E);
    rd_check(OFS_SYNC_CFG, SYNC_CFG_RST);
    rd_check(OFS_PHY_SETUP, 8'h00);
    rd_check(OFS_BERT_EN, 8'h00);
    rd_check(10'h3FF, 8'h00);
    for (int l = 0; l < NLANE; l++) check(llane[l][31:24], l);
    $display("test reset done");
    for (int p = 0; p < NPAIR; p++) begin
      reg_write(OFS_ROUTE_0 + 10'(p), {2'b11, 3'(6 - 2 * p), 3'(7 - 2 * p)});
      rd_check(OFS_ROUTE_0 + 10'(p), {2'b00, 3'(6 - 2 * p), 3'(7 - 2 * p)});
    end
    @(negedge clk_i);
    for (int l = 0; l < NLANE; l++) begin
      exp = {8'(7 - l), 8'h5A ^ 8'(7 - l), plane[0][15:0] - 16'h0001};
      check(llane[l], exp);
      exp = 32'((plane[0][7:0] - 8'h01) ^ 8'h3C);
      check(lvalid[l], exp[7 - l]);
    end
    $display("test crossbar done");
    @(posedge clk_i);
    full <= 8'h81;
    empty <= 8'h42;
    rd_check(OFS_FULL, 8'h81);
    rd_check(OFS_FULL, 8'h81);
    rd_check(OFS_EMPTY, 8'h42);
    reg_write(OFS_FULL, 8'hFF);
    @(posedge clk_i);
    full <= 8'h18;
    rd_check(OFS_FULL, 8'h18);
    rd_check(OFS_EMPTY, 8'h42);
    $display("test flags done");
    reg_write(OFS_PHY_SETUP, 8'h01);
    check(phy_w, 8'h01);
    rd_check(OFS_PHY_SETUP, 8'h01);
    for (int i = 0; i < NLANE; i++) begin
      reg_write(OFS_BERT_EN, 8'h01 << i);
      check(bert_w, 8'h01 << i);
    end
    rd_check(OFS_BERT_EN, 8'h80);
    $display("test setup done");
    reg_write(OFS_IRQ_CLR, 8'h07);
    reg_write(OFS_IRQ_EN, 8'h01);
    for (int d = 0; d < 4; d++) begin
      sync_run(2'(d), 1'b1, lows);
      check(lows, (d > 1) ? 2 : 1);
      check(irq, 1'b1);
      reg_write(OFS_IRQ_CLR, 8'h01);
      repeat (2) @(negedge clk_i);
      check(irq, 1'b0);
    end
    rd_check(OFS_SYNC_CFG, 8'h30);
    sync_run(2'h1, 1'b0, lows);
    check(lows, 0);
    $display("test sync done");
    reg_write(OFS_IRQ_EN, 8'h02);
    @(posedge clk_i);
    full <= 8'h00;
    @(posedge clk_i);
    full <= 8'h01;
    repeat (4) @(negedge clk_i);
    check(irq, 1'b1);
    reg_write(OFS_IRQ_EN, 8'h00);
    repeat (2) @(negedge clk_i);
    check(irq, 1'b0);
    reg_write(OFS_IRQ_STAT, 8'h00);
    rd_check(OFS_IRQ_STAT, 8'h02);
    reg_write(OFS_IRQ_CLR, 8'h02);
    rd_check(OFS_IRQ_STAT, 8'h00);
    rd_check(OFS_IRQ_CLR, 8'h00);
    rd_check(OFS_IRQ_EN, 8'h00);
    $display("test interrupt done");
    reg_write(OFS_ROUTE_0, 8'h3F);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_check(OFS_ROUTE_0, 8'h08);
    @(posedge clk_i);
    #1;
    check(rdata, 8'h00);
    rd_check(OFS_BERT_EN, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule : srlcs_bench
`default_nettype wire
